// file: inc/cp_ctl_pkg.sv
package cp_ctl_pkg;
    // Register location
    localparam logic [7:0] CTL_OFFSET      = 8'hC3;
    localparam logic [7:0] CTL_RESET       = 8'h00;
    // Bit positions
    localparam int         BIT_ENG_RESET   = 7;
    localparam int         BIT_RESERVED    = 6;
    localparam int         BIT_LIST_OK     = 5;
    localparam int         BIT_RX_OK       = 4;
    localparam int         BIT_CIPHER_OFF  = 3;
    localparam int         BIT_CIPHER_ON   = 2;
    localparam int         BIT_AUTH_OFF    = 1;
    localparam int         BIT_AUTH_EN     = 0;
    // Encryption policy codes
    localparam logic [1:0] POL_WHEN_AUTH   = 2'h0;
    localparam logic [1:0] POL_REG_CTL     = 2'h1;
    localparam logic [1:0] POL_ALWAYS      = 2'h2;
    localparam logic [1:0] POL_INBAND      = 2'h3;

    typedef enum logic [2:0] {
        VID_PLAIN  = 3'h1,
        VID_CIPHER = 3'h2,
        VID_BLUE   = 3'h4
    } video_mode_type;
endpackage

// file: rtl/content_protect_control.sv
// How it works
// - Writing one to bit 7 resets engine, disables authentication, bit self-clears.
// - Writing one to bit 5 lets repeater authentication finish; bit self-clears.
// - Bit 4 set lets authentication proceed; cleared by identity-ready flag.
// - Writing one to bit 3 sends plain video, keeps authentication; self-clears.
// - Bit 2 set under register policy: encrypted video if authenticated, else blue screen.
// - Bit 2 clear under register policy: video passes without encryption.
// - Always-encrypt policy makes bit 2 read-only, reading one.
// - Writing one to bit 1 disables authentication; bit self-clears.
// - Writing one to bit 0 starts or restarts authentication.
// - Writing zero to bit 0 does nothing; reads return authentication enabled.
// - Policy codes: 00 when-auth, 01 register, 10 always, 11 per-frame.
// - List-ready flag clears as soon as list approval is set, unless the hardware list-ready set comes in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module content_protect_control (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [1:0] enc_policy,
    input  wire logic       receiver_identity_ready,
    input  wire logic       list_ready_set,
    input  wire logic       authenticated,
    input  wire logic       inband_encrypt,
    output logic      [7:0] reg_rdata,
    output logic            protect_engine_reset,
    output logic            list_approved,
    output logic            receiver_approved,
    output logic            cipher_off,
    output logic            auth_off,
    output logic            auth_restart,
    output logic            auth_enabled,
    output logic            list_ready,
    output logic      [2:0] video_mode
);
    typedef struct packed {
        logic       eng_rst;
        logic       list_ok;
        logic       rx_ok;
        logic       ciph_off;
        logic       ciph_on;
        logic       a_off;
        logic       a_start;
        logic       a_en;
        logic       lst_rdy;
        logic [2:0] vmode;
        logic [7:0] rdata;
    } state_type;

    state_type s_q;
    state_type s_d;
    logic      wr_hit;
    logic      on_eff;
    logic      enc_want;

    // Register write decode
    assign wr_hit = reg_wr && (reg_addr == cp_ctl_pkg::CTL_OFFSET);

    always_comb begin
        s_d = s_q;
        // Command pulses last one cycle per write; back-to-back writes hold them high
        s_d.eng_rst  = wr_hit && reg_wdata[cp_ctl_pkg::BIT_ENG_RESET];
        s_d.list_ok  = wr_hit && reg_wdata[cp_ctl_pkg::BIT_LIST_OK];
        s_d.ciph_off = wr_hit && reg_wdata[cp_ctl_pkg::BIT_CIPHER_OFF];
        s_d.a_off    = wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_OFF];
        s_d.a_start  = wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_EN];
        // Receiver approval: the identity-ready clear wins, zero writes ignored
        if (wr_hit && reg_wdata[cp_ctl_pkg::BIT_RX_OK]) begin
            s_d.rx_ok = 1'b1;
        end
        if (receiver_identity_ready) begin
            s_d.rx_ok = 1'b0;
        end
        // Cipher-on is read-only under always-encrypt, so writes there leave the stored bit alone
        if (wr_hit && (enc_policy != cp_ctl_pkg::POL_ALWAYS)) begin
            s_d.ciph_on = reg_wdata[cp_ctl_pkg::BIT_CIPHER_ON];
        end
        // Enable follows start; reset or disable drops it
        if (wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_EN]) begin
            s_d.a_en = 1'b1;
        end
        if (wr_hit && (reg_wdata[cp_ctl_pkg::BIT_AUTH_OFF] || reg_wdata[cp_ctl_pkg::BIT_ENG_RESET])) begin
            s_d.a_en = 1'b0;
        end
        // Hardware set beats the approval clear so no list event is lost
        if (wr_hit && reg_wdata[cp_ctl_pkg::BIT_LIST_OK]) begin
            s_d.lst_rdy = 1'b0;
        end
        if (list_ready_set) begin
            s_d.lst_rdy = 1'b1;
        end
        // Read-back image; reserved bit and pulse bits read zero
        s_d.rdata = cp_ctl_pkg::CTL_RESET;
        s_d.rdata[cp_ctl_pkg::BIT_RX_OK]     = s_d.rx_ok;
        s_d.rdata[cp_ctl_pkg::BIT_CIPHER_ON] = s_d.ciph_on || (enc_policy == cp_ctl_pkg::POL_ALWAYS);
        s_d.rdata[cp_ctl_pkg::BIT_AUTH_EN]   = s_d.a_en;
        // Video path selection by policy
        on_eff = s_q.ciph_on || (enc_policy == cp_ctl_pkg::POL_ALWAYS);
        case (enc_policy)
            cp_ctl_pkg::POL_WHEN_AUTH: enc_want = authenticated;
            cp_ctl_pkg::POL_REG_CTL:   enc_want = on_eff;
            cp_ctl_pkg::POL_ALWAYS:    enc_want = 1'b1;
            default:                   enc_want = inband_encrypt;
        endcase
        // Blue screen only when cipher demanded without authentication
        if (!enc_want || s_d.ciph_off) begin
            s_d.vmode = cp_ctl_pkg::VID_PLAIN;
        end else if (authenticated) begin
            s_d.vmode = cp_ctl_pkg::VID_CIPHER;
        end else begin
            s_d.vmode = cp_ctl_pkg::VID_BLUE;
        end
    end

    // State register; synchronous reset to zero, except video mode, which loads plain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '{vmode: cp_ctl_pkg::VID_PLAIN, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata            = s_q.rdata;
    assign protect_engine_reset = s_q.eng_rst;
    assign list_approved        = s_q.list_ok;
    assign receiver_approved    = s_q.rx_ok;
    assign cipher_off           = s_q.ciph_off;
    assign auth_off             = s_q.a_off;
    assign auth_restart         = s_q.a_start;
    assign auth_enabled         = s_q.a_en;
    assign list_ready           = s_q.lst_rdy;
    assign video_mode           = s_q.vmode;

    // Command writes seen on the register port; each one owes a pulse on the next cycle
    sequence eng_rst_wr;
        wr_hit && reg_wdata[cp_ctl_pkg::BIT_ENG_RESET];
    endsequence
    sequence list_ok_wr;
        wr_hit && reg_wdata[cp_ctl_pkg::BIT_LIST_OK];
    endsequence
    sequence ciph_off_wr;
        wr_hit && reg_wdata[cp_ctl_pkg::BIT_CIPHER_OFF];
    endsequence
    sequence auth_off_wr;
        wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_OFF];
    endsequence
    sequence auth_en_wr;
        wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_EN];
    endsequence

    // Pulse checks are split in rise and drop, since back-to-back writes may hold a pulse high
    AST_RST_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        eng_rst_wr |=> protect_engine_reset)
        else $error("engine reset pulse missing");
    AST_RST_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        !(wr_hit && reg_wdata[cp_ctl_pkg::BIT_ENG_RESET]) |=> !protect_engine_reset)
        else $error("engine reset pulse stuck");
    AST_RST_DISABLES: assert property (@(posedge clk) disable iff (sys_rst)
        eng_rst_wr |=> !auth_enabled)
        else $error("engine reset left auth enabled");
    AST_LIST_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        list_ok_wr |=> list_approved)
        else $error("list approval missing");
    AST_LIST_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        !(wr_hit && reg_wdata[cp_ctl_pkg::BIT_LIST_OK]) |=> !list_approved)
        else $error("list approval pulse stuck");
    AST_RX_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
        receiver_identity_ready |=> !receiver_approved)
        else $error("receiver approval not cleared");
    AST_RX_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (receiver_approved && !receiver_identity_ready) |=> receiver_approved)
        else $error("receiver approval dropped");
    AST_CIPHER_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        ciph_off_wr |=> (video_mode == cp_ctl_pkg::VID_PLAIN) && cipher_off)
        else $error("cipher off not plain");
    AST_CIPHER_OFF_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        !(wr_hit && reg_wdata[cp_ctl_pkg::BIT_CIPHER_OFF]) |=> !cipher_off)
        else $error("cipher off pulse stuck");
    AST_ALWAYS_RO: assert property (@(posedge clk) disable iff (sys_rst)
        (enc_policy == cp_ctl_pkg::POL_ALWAYS) ##1 (enc_policy == cp_ctl_pkg::POL_ALWAYS)
        |-> reg_rdata[cp_ctl_pkg::BIT_CIPHER_ON])
        else $error("cipher on not read as one");
    AST_ALWAYS_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
        (enc_policy == cp_ctl_pkg::POL_ALWAYS) |=> $stable(s_q.ciph_on))
        else $error("cipher on written under always policy");
    AST_PLAIN_WHEN_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        ((enc_policy == cp_ctl_pkg::POL_REG_CTL) && !s_q.ciph_on) |=> (video_mode == cp_ctl_pkg::VID_PLAIN))
        else $error("video not plain with cipher off");
    AST_BLUE_UNAUTH: assert property (@(posedge clk) disable iff (sys_rst)
        ((enc_policy == cp_ctl_pkg::POL_REG_CTL) && s_q.ciph_on && !authenticated
            && !(wr_hit && reg_wdata[cp_ctl_pkg::BIT_CIPHER_OFF])) |=> (video_mode == cp_ctl_pkg::VID_BLUE))
        else $error("blue screen missing");
    AST_CIPHER_AUTH: assert property (@(posedge clk) disable iff (sys_rst)
        ((enc_policy == cp_ctl_pkg::POL_REG_CTL) && s_q.ciph_on && authenticated
            && !(wr_hit && reg_wdata[cp_ctl_pkg::BIT_CIPHER_OFF])) |=> (video_mode == cp_ctl_pkg::VID_CIPHER))
        else $error("encrypted video missing");
    AST_AUTH_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        auth_off_wr |=> auth_off && !auth_enabled)
        else $error("auth off wrong");
    AST_AUTH_OFF_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        !(wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_OFF]) |=> !auth_off)
        else $error("auth off pulse stuck");
    AST_START_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        auth_en_wr |=> auth_restart)
        else $error("auth restart pulse missing");
    AST_AUTH_START: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_EN] && !reg_wdata[cp_ctl_pkg::BIT_AUTH_OFF]
            && !reg_wdata[cp_ctl_pkg::BIT_ENG_RESET])
        |=> auth_restart && auth_enabled && reg_rdata[cp_ctl_pkg::BIT_AUTH_EN])
        else $error("auth start wrong");
    AST_START_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        !(wr_hit && reg_wdata[cp_ctl_pkg::BIT_AUTH_EN]) |=> !auth_restart)
        else $error("auth restart pulse stuck");
    AST_ZERO_NOEFFECT: assert property (@(posedge clk) disable iff (sys_rst)
        (auth_enabled && !(wr_hit && (reg_wdata[cp_ctl_pkg::BIT_AUTH_OFF] || reg_wdata[cp_ctl_pkg::BIT_ENG_RESET])))
        |=> auth_enabled)
        else $error("auth enable lost");
    AST_LIST_READY: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_hit && reg_wdata[cp_ctl_pkg::BIT_LIST_OK] && !list_ready_set) |=> !list_ready)
        else $error("list ready not cleared");
    AST_RESERVED: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rdata[cp_ctl_pkg::BIT_RESERVED] && !reg_rdata[cp_ctl_pkg::BIT_ENG_RESET]
        && !reg_rdata[cp_ctl_pkg::BIT_LIST_OK])
        else $error("reserved or pulse bit read one");
endmodule
`default_nettype wire

// file: test/content_protect_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module content_protect_control_bench;
    logic       clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, rid_rdy = 1'b0, lr_set = 1'b0, auth = 1'b0, inb = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic [1:0] pol = cp_ctl_pkg::POL_REG_CTL;
    logic       eng_rst, list_ok, rx_ok, c_off, a_off, a_rst, a_en, list_rdy;
    logic [2:0] vm;
    logic       m_en = 1'b0, m_rx = 1'b0, m_con = 1'b0, m_lr = 1'b0;
    int         err_total = 0, checks_done = 0;
    content_protect_control u_content_protect_control (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .enc_policy(pol), .receiver_identity_ready(rid_rdy),
        .list_ready_set(lr_set), .authenticated(auth), .inband_encrypt(inb), .reg_rdata(reg_rdata),
        .protect_engine_reset(eng_rst), .list_approved(list_ok), .receiver_approved(rx_ok), .cipher_off(c_off),
        .auth_off(a_off), .auth_restart(a_rst), .auth_enabled(a_en), .list_ready(list_rdy), .video_mode(vm));
    // Free-running 25 MHz clock
    always #20 clk = ~clk;
    task print_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task step();
        @(posedge clk);
        @(negedge clk);
    endtask
    // Read image expected from the model; policy always forces the cipher-on bit high
    function logic [7:0] exp_rd();
        return {3'h0, m_rx, 1'b0, (pol == cp_ctl_pkg::POL_ALWAYS) | m_con, 1'b0, m_en};
    endfunction
    // Policy picks whether encryption is demanded; demanded without authentication means blue screen
    function logic [2:0] exp_vm();
        logic want;
        case (pol)
            cp_ctl_pkg::POL_WHEN_AUTH: want = auth;
            cp_ctl_pkg::POL_REG_CTL:   want = m_con;
            cp_ctl_pkg::POL_ALWAYS:    want = 1'b1;
            default:                   want = inb;
        endcase
        if (!want) return cp_ctl_pkg::VID_PLAIN;
        return auth ? cp_ctl_pkg::VID_CIPHER : cp_ctl_pkg::VID_BLUE;
    endfunction
    // One write, then the pulse cycle and the settled cycle after it are compared
    task wr(input logic [7:0] a, input logic [7:0] v);
        logic hit;
        hit = (a == cp_ctl_pkg::CTL_OFFSET);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
        if (hit) begin
            if (v[7] | v[1]) m_en = 1'b0;
            else if (v[0]) m_en = 1'b1;
            if (v[4]) m_rx = 1'b1;
            if (pol != cp_ctl_pkg::POL_ALWAYS) m_con = v[2];
            if (v[5]) m_lr = 1'b0;
        end
        chk({3'h0, eng_rst, list_ok, c_off, a_off, a_rst}, hit ? {3'h0, v[7], v[5], v[3], v[1], v[0]} : 8'h00);
        chk(reg_rdata & 8'h55, exp_rd() & 8'h55);
        if (hit && v[3]) chk({5'h0, vm}, {5'h0, cp_ctl_pkg::VID_PLAIN});
        step();
        chk({3'h0, eng_rst, list_ok, c_off, a_off, a_rst}, 8'h00);
        chk(reg_rdata, exp_rd());
        chk({5'h0, a_en, rx_ok, list_rdy}, {5'h0, m_en, m_rx, m_lr});
        chk({5'h0, vm}, {5'h0, exp_vm()});
    endtask
    initial begin
        void'($urandom(32'hFBE468DB));
        repeat (12) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk(reg_rdata, cp_ctl_pkg::CTL_RESET);
        chk({2'h0, eng_rst, list_ok, rx_ok, c_off, a_off, a_rst}, 8'h00);
        chk({3'h0, a_en, list_rdy, vm}, 8'h01);
        // Enable, restart, then the engine reset and auth-off both drop it
        wr(8'hC3, 8'h01);
        wr(8'hC3, 8'h01);
        wr(8'hC3, 8'h80);
        wr(8'hC3, 8'h01);
        wr(8'hC3, 8'h02);
        // Neighbouring addresses are ignored
        wr(8'hC2, 8'h3D);
        wr(8'hC4, 8'h01);
        // List ready is cleared by the list approval write
        lr_set = 1'b1;
        step();
        lr_set = 1'b0;
        m_lr = 1'b1;
        step();
        chk({7'h0, list_rdy}, 8'h01);
        wr(8'hC3, 8'h20);
        // Receiver approval holds over a zero write and drops on identity ready
        wr(8'hC3, 8'h51);
        wr(8'hC3, 8'h00);
        rid_rdy = 1'b1;
        step();
        rid_rdy = 1'b0;
        m_rx = 1'b0;
        step();
        chk({7'h0, rx_ok}, 8'h00);
        // Cipher kept on under register control: encrypted when authenticated, blue when not
        auth = 1'b1;
        wr(8'hC3, 8'h04);
        auth = 1'b0;
        step();
        chk({5'h0, vm}, {5'h0, cp_ctl_pkg::VID_BLUE});
        wr(8'hC3, 8'h0C);
        // Random policies and writes; engine reset and auth-off kept out so the pulse model stays exact
        for (int i = 0; i < 60; i++) begin
            pol = 2'($urandom);
            auth = 1'($urandom);
            inb = 1'($urandom);
            d = 8'($urandom) & 8'h7D;
            wr(8'hC3, d);
        end
        // A second reset in mid-run clears all state except video mode, which loads plain; the next write is taken at once
        pol = cp_ctl_pkg::POL_REG_CTL;
        sys_rst = 1'b1;
        step();
        sys_rst = 1'b0;
        m_en = 1'b0;
        m_rx = 1'b0;
        m_con = 1'b0;
        m_lr = 1'b0;
        chk(reg_rdata, cp_ctl_pkg::CTL_RESET);
        chk({3'h0, a_en, list_rdy, vm}, 8'h01);
        wr(8'hC3, 8'h15);
        print_verdict();
    end
endmodule
`default_nettype wire
